/* core/adc_ctl_pkg.sv */
// Purpose: shared constants for the converter control block
// Assumes: 8-bit register port, one clock domain
// Notes:   offsets and field positions used by the control logic
package adc_ctl_pkg;
    // register indices on the plain register port
    localparam logic [2:0] OFS_SC1  = 3'h0;
    localparam logic [2:0] OFS_SC2  = 3'h1;
    localparam logic [2:0] OFS_CFG  = 3'h2;
    localparam logic [2:0] OFS_RH   = 3'h3;
    localparam logic [2:0] OFS_RL   = 3'h4;
    localparam logic [2:0] OFS_CVH  = 3'h5;
    localparam logic [2:0] OFS_CVL  = 3'h6;
    localparam logic [2:0] OFS_PC3  = 3'h7;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    // status_control_one fields
    localparam int SC1_CONVERSION_COMPLETE_FLAG  = 7;
    localparam int SC1_COMPLETE_IRQ_ENABLE  = 6;
    localparam int SC1_CONTINUOUS_ENABLE  = 5;
    localparam int CH_W      = 5;
    localparam logic [4:0] CH_OFF = 5'h1F;
    localparam logic [4:0] CH_MAX = 5'h1B;
    // status_control_two fields
    localparam int SC2_BUSY  = 7;
    localparam int SC2_HWTRG = 6;
    localparam int SC2_COMPARE_ENABLE  = 5;
    localparam int SC2_ACFGT = 4;
    // converter_config_reg fields
    localparam int CFG_LSMP  = 4;
    localparam int CFG_MODE  = 2;
    localparam int CFG_CLK   = 0;
    localparam logic [1:0] MODE_8  = 2'h0;
    localparam logic [1:0] MODE_12 = 2'h1;
    localparam logic [1:0] MODE_10 = 2'h2;
    // clock sources
    localparam logic [1:0] CLK_BUS   = 2'h0;
    localparam logic [1:0] CLK_HALF  = 2'h1;
    localparam logic [1:0] CLK_ALT   = 2'h2;
    localparam logic [1:0] CLK_ASYNC = 2'h3;
    // sample periods in conversion clocks
    localparam logic [4:0] SMP_SHORT = 5'h03;
    localparam logic [4:0] SMP_LONG  = 5'h13;
    // clocks a new trial code needs to cross the comparator synchroniser
    localparam logic [4:0] CMP_SETTLE = 5'h04;
    // raw widths less one
    localparam logic [3:0] BITS_12 = 4'hB;
    localparam logic [3:0] BITS_9  = 4'h8;
    localparam int RES_W = 12;
    // synchronised pin inputs
    localparam int PIN_N    = 4;
    localparam int PIN_COMP = 0;
    localparam int PIN_TRIG = 1;
    localparam int PIN_ALT  = 2;
    localparam int PIN_ASYN = 3;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b10,
        ST_XFER   = 2'b11
    } sar_state_t;
endpackage : adc_ctl_pkg

/* core/adc_conversion_control.sv */
// Purpose: control of a 12-bit successive-approximation converter
// Assumes: analog comparator and trial DAC outside, one clock
// Notes:   registers on a plain strobe port, read data one cycle later
`timescale 1ns/1ps
module adc_conversion_control
    import adc_ctl_pkg::*;
(
    // clock and reset
    input  wire logic                              CLK,
    input  wire logic                              RST,
    // register port
    input  wire logic [adc_ctl_pkg::ADDR_W-1:0]    ADDR,
    input  wire logic [adc_ctl_pkg::DATA_W-1:0]    WDATA,
    input  wire logic                              WR,
    input  wire logic                              RD,
    output logic      [adc_ctl_pkg::DATA_W-1:0]    RDATA,
    // pins from outside the clock domain
    input  wire logic                              COMP_IN,
    input  wire logic                              HW_TRIG,
    input  wire logic                              ALT_CLK,
    input  wire logic                              ASYNC_CLK,
    input  wire logic                              STOP_REQ,
    // analog core control
    output logic      [adc_ctl_pkg::RES_W-1:0]     TRIAL_CODE,
    output logic      [adc_ctl_pkg::CH_W-1:0]      CHANNEL,
    output logic                                   SAMPLE,
    output logic                                   POWER_ON,
    output logic      [7:0]                        PIN_DISABLE,
    output logic                                   IRQ
);
    import adc_ctl_pkg::*;

    function automatic logic [RES_W-1:0] fmt_result(
        input logic [RES_W-1:0] raw, input logic [1:0] mode);
        logic [RES_W:0] sum;
        sum = '0;
        fmt_result = raw;
        if (mode == MODE_10) begin
            sum = {1'b0, raw} + 13'h0002;
            fmt_result = sum[RES_W] ? 12'h03FF : {2'h0, sum[11:2]};
        end else if (mode == MODE_8) begin
            sum = {4'h0, raw[8:0]} + 13'h0001;
            fmt_result = sum[9] ? 12'h00FF : {4'h0, sum[8:1]};
        end
    endfunction : fmt_result

    // synchronisers: three flops, change accepted when 2nd and 3rd agree
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] s1_r, s2_r, s3_r, flt_r, flt_nxt, flt_d_r;
    assign pin_raw = {ASYNC_CLK, ALT_CLK, HW_TRIG, COMP_IN};
    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_sync
            always_comb begin
                flt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : flt_r[gi];
            end
            always_ff @(posedge CLK) begin
                if (RST) begin
                    s1_r[gi]    <= 1'b0;
                    s2_r[gi]    <= 1'b0;
                    s3_r[gi]    <= 1'b0;
                    flt_r[gi]   <= 1'b0;
                    flt_d_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi]    <= pin_raw[gi];
                    s2_r[gi]    <= s1_r[gi];
                    s3_r[gi]    <= s2_r[gi];
                    flt_r[gi]   <= flt_nxt[gi];
                    flt_d_r[gi] <= flt_r[gi];
                end
            end
        end
    endgenerate
    logic [PIN_N-1:0] pin_rise;
    assign pin_rise = flt_r & ~flt_d_r;

    // register and conversion state
    logic [DATA_W-1:0]  rdata_r, rdata_nxt;
    logic               complete_irq_enable_r, complete_irq_enable_nxt, continuous_enable_r, continuous_enable_nxt;
    logic [CH_W-1:0]    ch_r, ch_nxt;
    logic               hwtrg_r, hwtrg_nxt, compare_enable_r, compare_enable_nxt;
    logic               acfgt_r, acfgt_nxt;
    logic               lsmp_r, lsmp_nxt;
    logic [1:0]         mode_r, mode_nxt, clksel_r, clksel_nxt;
    logic [RES_W-1:0]   cv_r, cv_nxt, res_r, res_nxt;
    logic [7:0]         pc3_r, pc3_nxt;
    logic               conversion_complete_flag_r, conversion_complete_flag_nxt, block_r, block_nxt;
    logic               irq_r, irq_nxt, half_r, half_nxt;
    sar_state_t         state_r, state_nxt;
    logic [RES_W-1:0]   sar_r, sar_nxt;
    logic [3:0]         bit_r, bit_nxt;
    logic [4:0]         cnt_r, cnt_nxt;
    logic               sample_r, sample_nxt, power_r, power_nxt;

    logic conv_tick, sw_start, cfg_abort, stop_abort, hw_start;
    logic cmp_ok, blocked, single_miss;
    logic [RES_W-1:0] fmt_val, raw_val;

    always_comb begin
        case (clksel_r)
            CLK_BUS:   conv_tick = 1'b1;
            CLK_HALF:  conv_tick = half_r;
            CLK_ALT:   conv_tick = pin_rise[PIN_ALT];
            CLK_ASYNC: conv_tick = pin_rise[PIN_ASYN];
            default:   conv_tick = 1'b0;
        endcase
    end

    assign sw_start   = WR && (ADDR == OFS_SC1)
                        && (WDATA[CH_W-1:0] != CH_OFF)
                        && !hwtrg_r;
    assign cfg_abort  = WR && (ADDR == OFS_SC2 || ADDR == OFS_CFG
                        || ADDR == OFS_CVH || ADDR == OFS_CVL);
    // async clock keeps running in stop, so only then does it survive
    assign stop_abort = STOP_REQ && (clksel_r != CLK_ASYNC);
    assign hw_start   = hwtrg_r && pin_rise[PIN_TRIG]
                        && (ch_r != CH_OFF);
    // 9-bit raw sits high in the sar word in 8-bit mode
    assign raw_val = (mode_r == MODE_8) ? {3'h0, sar_r[11:3]} : sar_r;
    assign fmt_val = fmt_result(raw_val, mode_r);
    assign cmp_ok  = !compare_enable_r || (acfgt_r ? (fmt_val >= cv_r)
                                         : (fmt_val < cv_r));
    assign blocked = block_r && (mode_r != MODE_8);
    assign single_miss = compare_enable_r && !cmp_ok && !continuous_enable_r;

    always_comb begin
        complete_irq_enable_nxt   = complete_irq_enable_r;
        continuous_enable_nxt   = continuous_enable_r;
        ch_nxt     = ch_r;
        hwtrg_nxt  = hwtrg_r;
        compare_enable_nxt   = compare_enable_r;
        acfgt_nxt  = acfgt_r;
        lsmp_nxt   = lsmp_r;
        mode_nxt   = mode_r;
        clksel_nxt = clksel_r;
        cv_nxt     = cv_r;
        pc3_nxt    = pc3_r;
        res_nxt    = res_r;
        conversion_complete_flag_nxt   = conversion_complete_flag_r;
        block_nxt  = block_r;
        state_nxt  = state_r;
        sar_nxt    = sar_r;
        bit_nxt    = bit_r;
        cnt_nxt    = cnt_r;
        rdata_nxt  = '0;
        half_nxt   = !half_r;
        if (RD) begin
            case (ADDR)
                OFS_SC1: rdata_nxt = {conversion_complete_flag_r, complete_irq_enable_r, continuous_enable_r, ch_r};
                OFS_SC2: rdata_nxt = {state_r != ST_IDLE, hwtrg_r,
                                      compare_enable_r, acfgt_r, 4'h0};
                OFS_CFG: rdata_nxt = {3'h0, lsmp_r, mode_r, clksel_r};
                OFS_RH:  rdata_nxt = {4'h0, res_r[11:8]};
                OFS_RL:  rdata_nxt = res_r[7:0];
                OFS_CVH: rdata_nxt = {4'h0, cv_r[11:8]};
                OFS_CVL: rdata_nxt = cv_r[7:0];
                OFS_PC3: rdata_nxt = pc3_r;
                default: rdata_nxt = '0;
            endcase
            // a high read arms the lock outside 8-bit mode, the low read releases it
            if (ADDR == OFS_RH && mode_r != MODE_8) begin
                block_nxt = 1'b1;
            end
            if (ADDR == OFS_RL) begin
                block_nxt = 1'b0;
                conversion_complete_flag_nxt  = 1'b0;
            end
        end
        if (WR) begin
            case (ADDR)
                OFS_SC1: begin
                    complete_irq_enable_nxt = WDATA[SC1_COMPLETE_IRQ_ENABLE];
                    continuous_enable_nxt = WDATA[SC1_CONTINUOUS_ENABLE];
                    ch_nxt   = WDATA[CH_W-1:0];
                    conversion_complete_flag_nxt = 1'b0;
                end
                OFS_SC2: begin
                    hwtrg_nxt = WDATA[SC2_HWTRG];
                    compare_enable_nxt  = WDATA[SC2_COMPARE_ENABLE];
                    acfgt_nxt = WDATA[SC2_ACFGT];
                end
                OFS_CFG: begin
                    lsmp_nxt   = WDATA[CFG_LSMP];
                    mode_nxt   = WDATA[CFG_MODE +: 2];
                    clksel_nxt = WDATA[CFG_CLK +: 2];
                end
                OFS_CVH: cv_nxt[11:8] = WDATA[3:0];
                OFS_CVL: cv_nxt[7:0]  = WDATA;
                OFS_PC3: pc3_nxt = WDATA;
                default: ;
            endcase
        end
        case (state_r)
            ST_IDLE: begin
                sar_nxt = '0;
                if (hw_start) begin
                    state_nxt = ST_SAMPLE;
                    cnt_nxt   = lsmp_r ? SMP_LONG : SMP_SHORT;
                end
            end
            ST_SAMPLE: begin
                if (conv_tick) begin
                    if (cnt_r == '0) begin
                        // 9-bit runs use the top nine trial positions
                        state_nxt = ST_CONV;
                        bit_nxt   = BITS_12;
                        sar_nxt   = '0;
                        sar_nxt[BITS_12] = 1'b1;
                        cnt_nxt   = CMP_SETTLE;
                    end else begin
                        cnt_nxt = cnt_r - 5'h01;
                    end
                end
            end
            ST_CONV: begin
                // comparator high keeps the trial bit; each decision waits
                // out the pin synchroniser, so a bit costs at least the
                // settle count in clocks even on the fastest source
                if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - 5'h01;
                end else if (conv_tick) begin
                    sar_nxt[bit_r] = flt_r[PIN_COMP];
                    if (bit_r == (BITS_12 - ((mode_r == MODE_8) ?
                                 BITS_9 : BITS_12))) begin
                        state_nxt = ST_XFER;
                    end else begin
                        sar_nxt[bit_r - 4'h1] = 1'b1;
                        bit_nxt = bit_r - 4'h1;
                        cnt_nxt = CMP_SETTLE;
                    end
                end
            end
            ST_XFER: begin
                cnt_nxt = lsmp_r ? SMP_LONG : SMP_SHORT;
                if (single_miss) begin
                    state_nxt = ST_IDLE;
                end else if (!cmp_ok) begin
                    state_nxt = ST_SAMPLE;
                end else if (blocked) begin
                    state_nxt = ST_SAMPLE;
                end else begin
                    res_nxt   = fmt_val;
                    conversion_complete_flag_nxt  = 1'b1;
                    state_nxt = continuous_enable_r ? ST_SAMPLE : ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (cfg_abort || stop_abort || ch_nxt == CH_OFF) begin
            state_nxt = ST_IDLE;
        end
        if (WR && ADDR == OFS_SC1) begin
            state_nxt = sw_start ? ST_SAMPLE : ST_IDLE;
            cnt_nxt   = lsmp_r ? SMP_LONG : SMP_SHORT;
        end
        irq_nxt = conversion_complete_flag_r && complete_irq_enable_r;
        sample_nxt = (state_nxt == ST_SAMPLE);
        power_nxt  = (state_nxt != ST_IDLE);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_r  <= '0;
            complete_irq_enable_r   <= 1'b0;
            continuous_enable_r   <= 1'b0;
            ch_r     <= CH_OFF;
            hwtrg_r  <= 1'b0;
            compare_enable_r   <= 1'b0;
            acfgt_r  <= 1'b0;
            lsmp_r   <= 1'b0;
            mode_r   <= MODE_8;
            clksel_r <= CLK_BUS;
            cv_r     <= '0;
            pc3_r    <= '0;
            res_r    <= '0;
            conversion_complete_flag_r   <= 1'b0;
            block_r  <= 1'b0;
            irq_r    <= 1'b0;
            half_r   <= 1'b0;
            state_r  <= ST_IDLE;
            sar_r    <= '0;
            bit_r    <= '0;
            cnt_r    <= '0;
            sample_r <= 1'b0;
            power_r  <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            complete_irq_enable_r   <= complete_irq_enable_nxt;
            continuous_enable_r   <= continuous_enable_nxt;
            ch_r     <= ch_nxt;
            hwtrg_r  <= hwtrg_nxt;
            compare_enable_r   <= compare_enable_nxt;
            acfgt_r  <= acfgt_nxt;
            lsmp_r   <= lsmp_nxt;
            mode_r   <= mode_nxt;
            clksel_r <= clksel_nxt;
            cv_r     <= cv_nxt;
            pc3_r    <= pc3_nxt;
            res_r    <= res_nxt;
            conversion_complete_flag_r   <= conversion_complete_flag_nxt;
            block_r  <= block_nxt;
            irq_r    <= irq_nxt;
            half_r   <= half_nxt;
            state_r  <= state_nxt;
            sar_r    <= sar_nxt;
            bit_r    <= bit_nxt;
            cnt_r    <= cnt_nxt;
            sample_r <= sample_nxt;
            power_r  <= power_nxt;
        end
    end

    assign RDATA       = rdata_r;
    assign TRIAL_CODE  = sar_r;
    assign CHANNEL     = ch_r;
    assign SAMPLE      = sample_r;
    assign POWER_ON    = power_r;
    assign PIN_DISABLE = pc3_r;
    assign IRQ         = irq_r;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence seq_xfer;
        state_r == ST_XFER && !cfg_abort && !stop_abort && !WR;
    endsequence
    sequence seq_xfer_ok;
        seq_xfer ##0 (cmp_ok && !blocked);
    endsequence

    AST_DISABLED: assert property (
        ch_r == CH_OFF |-> state_r == ST_IDLE)
        else $error("converter active with channel off");
    AST_SW_START: assert property (
        sw_start |=> state_r == ST_SAMPLE ##1 state_r != ST_IDLE)
        else $error("software start not taken");
    AST_HW_START: assert property (
        state_r == ST_IDLE && hw_start && !WR && !stop_abort
        |=> state_r == ST_SAMPLE)
        else $error("hardware trigger not taken");
    AST_CONVERSION_COMPLETE_FLAG: assert property (
        seq_xfer_ok |=> conversion_complete_flag_r && res_r == $past(fmt_val))
        else $error("transfer did not set complete flag");
    AST_IRQ: assert property (
        conversion_complete_flag_r && complete_irq_enable_r |=> IRQ)
        else $error("interrupt missing");
    AST_BLOCK: assert property (
        seq_xfer ##0 (cmp_ok && blocked) |=>
        $stable(res_r) && state_r == ST_SAMPLE)
        else $error("blocked transfer wrote result");
    AST_CONT: assert property (
        seq_xfer_ok ##0 continuous_enable_r |=> state_r == ST_SAMPLE)
        else $error("continuous mode did not restart");
    AST_SINGLE_MISS: assert property (
        seq_xfer ##0 single_miss |=> state_r == ST_IDLE && !$rose(conversion_complete_flag_r))
        else $error("single compare miss did not stop");
    AST_ABORT: assert property (
        cfg_abort |=> state_r == ST_IDLE)
        else $error("configuration write did not abort");
    AST_STOP: assert property (
        stop_abort && !WR |=> state_r == ST_IDLE)
        else $error("stop entry did not abort");
endmodule : adc_conversion_control

/* dv/adc_far_side.sv */
// Purpose: far side model: analog channel levels, trigger source, clocks
// Assumes: ideal comparator, levels loaded by the bench
// Notes:   unselected channels give a toggling comparator, never a hold
`timescale 1ns/1ps
module adc_far_side
    import adc_ctl_pkg::*;
(
    // clock
    input  wire logic                          CLK,
    // analog core control
    input  wire logic [adc_ctl_pkg::RES_W-1:0] TRIAL_CODE,
    input  wire logic [adc_ctl_pkg::CH_W-1:0]  CHANNEL,
    // bench request
    input  wire logic                          TRIG_GO,
    // pins to the design
    output logic                               COMP_IN,
    output logic                               HW_TRIG,
    output logic                               ALT_CLK,
    output logic                               ASYNC_CLK
);
    import adc_ctl_pkg::*;
    logic [RES_W-1:0] lvl [0:27];
    logic [3:0]       div_r = 4'h0;
    logic [3:0]       trig_r = 4'h0;
    logic             tog_r = 1'b0;
    initial ASYNC_CLK = 1'b0;
    // free running, unrelated in phase to the bus clock
    always #730 ASYNC_CLK = ~ASYNC_CLK;
    always_ff @(posedge CLK) begin
        div_r  <= div_r + 4'h1;
        tog_r  <= ~tog_r;
        // long pulse so the synchronised edge is seen once
        trig_r <= TRIG_GO ? 4'hC
                  : ((trig_r != 4'h0) ? trig_r - 4'h1 : trig_r);
    end
    assign ALT_CLK = div_r[3];
    assign HW_TRIG = (trig_r != 4'h0);
    always_comb begin
        if (CHANNEL < 5'h1C) begin
            COMP_IN = (lvl[CHANNEL] >= TRIAL_CODE);
        end else begin
            COMP_IN = tog_r;
        end
    end
endmodule : adc_far_side

/* dv/tb.sv */
// Purpose: self-checking bench of the converter control block
// Assumes: register port with read data one cycle after the strobe
// Notes:   flag polled through status one only while converting
`timescale 1ns/1ps
module tb;
    import adc_ctl_pkg::*;
    logic              clk = 0, rst = 1, wr = 0, rd = 0, stop_req = 0;
    logic              trig_go = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, pin_disable;
    logic [RES_W-1:0]  trial_code;
    logic [CH_W-1:0]   channel;
    logic              comp_in, hw_trig, alt_clk, async_clk;
    logic              sample, power_on, irq;
    int                fail_count = 0, n_compared = 0, cycles = 0;
    logic [7:0]        d, h, l;
    logic [11:0]       v, v2;
    bit                f;
    always #50 clk = ~clk;
    adc_conversion_control adc_conversion_control_i (
        .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .COMP_IN(comp_in), .HW_TRIG(hw_trig),
        .ALT_CLK(alt_clk), .ASYNC_CLK(async_clk), .STOP_REQ(stop_req),
        .TRIAL_CODE(trial_code), .CHANNEL(channel), .SAMPLE(sample),
        .POWER_ON(power_on), .PIN_DISABLE(pin_disable), .IRQ(irq));
    adc_far_side adc_far_side_i (
        .CLK(clk), .TRIAL_CODE(trial_code), .CHANNEL(channel),
        .TRIG_GO(trig_go), .COMP_IN(comp_in), .HW_TRIG(hw_trig),
        .ALT_CLK(alt_clk), .ASYNC_CLK(async_clk));
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrt(input logic [2:0] a, input logic [7:0] dv);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= dv;
        @(posedge clk);
        wr <= 1'b0;
        // step off the edge so callers see the updated outputs
        #1;
    endtask : wrt
    task automatic rdr(input logic [2:0] a, output logic [7:0] dv);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 dv = rdata;
    endtask : rdr
    // only status one is read while a conversion runs
    task automatic wait_done(input int n, output bit fd);
        logic [7:0] s;
        fd = 0;
        for (int i = 0; i < n && !fd; i++) begin
            rdr(OFS_SC1, s);
            fd = (s[SC1_CONVERSION_COMPLETE_FLAG] === 1'b1);
        end
    endtask : wait_done
    function automatic logic [11:0] fmt(input logic [11:0] x,
                                        input logic [1:0] md);
        logic [12:0] s;
        if (md == MODE_12) return x;
        if (md == MODE_10) begin
            s = (13'(x) + 13'h2) >> 2;
            return (s > 13'h03FF) ? 12'h3FF : s[11:0];
        end
        s = (13'(x[11:3]) + 13'h1) >> 1;
        return (s > 13'h00FF) ? 12'h0FF : s[11:0];
    endfunction : fmt
    task automatic result(input logic [11:0] exp);
        rdr(OFS_RH, h);
        rdr(OFS_RL, l);
        check("result", {h[3:0], l}, exp);
    endtask : result
    task automatic run_one(input logic [1:0] md, input logic [1:0] cs,
                           input logic [4:0] ch, input logic [11:0] x);
        logic a;
        a = 1'($urandom);
        adc_far_side_i.lvl[ch] = x;
        wrt(OFS_CFG, {3'h0, 1'($urandom), md, cs});
        wrt(OFS_SC1, {1'b0, a, 1'b0, ch});
        check("channel", channel, ch);
        check("sampling", sample, 1);
        wait_done(400, f);
        check("complete", f, 1);
        check("irq", irq, a);
        result(fmt(x, md));
        check("idle", power_on, 0);
        check("idle trial", {sample, trial_code}, 0);
    endtask : run_one
    initial begin
        logic [2:0] at [4] = '{OFS_SC2, OFS_CFG, OFS_CVH, OFS_CVL};
        logic [1:0] ct [2] = '{CLK_BUS, CLK_ASYNC};
        void'($urandom(32'h923f_1f33));
        for (int i = 0; i < 28; i++) adc_far_side_i.lvl[i] = 12'h000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdr(OFS_SC1, d);
        check("sc1 reset", d, 8'h1F);
        check("off", power_on, 0);
        check("pins reset", pin_disable, 8'h00);
        d = 8'($urandom);
        wrt(OFS_PC3, d);
        rdr(OFS_PC3, h);
        check("pins", h, d);
        check("pin out", pin_disable, d);
        wrt(OFS_SC1, 8'h1F);
        wait_done(30, f);
        check("disabled", {f, power_on}, 0);
        $display("done: reset and pins");
        foreach (ct[k]) begin
            for (int c = 0; c < 4; c++) begin
                run_one(k ? MODE_10 : MODE_12, c, 5'($urandom % 28),
                        12'($urandom));
            end
        end
        for (int c = 0; c < 4; c++) run_one(MODE_8, c, 5'($urandom % 28),
                                            12'($urandom));
        run_one(MODE_10, CLK_BUS, 5'd27, 12'hFFF);
        run_one(MODE_8, CLK_BUS, 5'd16, 12'hFFF);
        run_one(MODE_8, CLK_BUS, 5'd0, 12'h004);
        $display("done: conversions");
        v = 12'($urandom % 4095);
        adc_far_side_i.lvl[3] = v;
        wrt(OFS_CFG, {5'h0, CLK_BUS} | {4'h0, MODE_12, 2'h0});
        wrt(OFS_CVH, {4'h0, 4'(({4'h0, v} + 16'h1) >> 8)});
        wrt(OFS_CVL, 8'(v + 12'h1));
        wrt(OFS_SC2, 8'h30);
        wrt(OFS_SC1, 8'h03);
        wait_done(100, f);
        check("cmp false", {f, power_on}, 0);
        wrt(OFS_SC2, 8'h20);
        wrt(OFS_SC1, 8'h03);
        wait_done(100, f);
        check("cmp true", f, 1);
        result(v);
        $display("done: compare");
        wrt(OFS_SC2, 8'h40);
        wrt(OFS_SC1, 8'h03);
        wait_done(60, f);
        check("no trig", f, 0);
        @(posedge clk) trig_go <= 1'b1;
        @(posedge clk) trig_go <= 1'b0;
        wait_done(100, f);
        check("trig", f, 1);
        result(v);
        wrt(OFS_SC2, 8'h00);
        wrt(OFS_SC1, 8'h23);
        wait_done(100, f);
        rdr(OFS_RL, d);
        wait_done(100, f);
        check("continuous", f, 1);
        wrt(OFS_SC1, 8'h1F);
        $display("done: trigger and continuous");
        wrt(OFS_SC1, 8'h03);
        rdr(OFS_RH, d); // deliberately against the read discipline
        v2 = 12'($urandom);
        adc_far_side_i.lvl[3] = v2;
        wait_done(100, f);
        check("blocked", f, 0);
        check("restart", power_on, 1);
        rdr(OFS_RL, d);
        wait_done(100, f);
        check("unblocked", f, 1);
        result(v2);
        $display("done: blocking");
        adc_far_side_i.lvl[9] = ~v2;
        wrt(OFS_SC1, 8'h03);
        repeat (6) @(posedge clk);
        wrt(OFS_SC1, 8'h09);
        wait_done(100, f);
        check("restart sc1", f, 1);
        result(~v2);
        foreach (at[k]) begin
            wrt(OFS_SC1, 8'h09);
            repeat (6) @(posedge clk);
            wrt(at[k], (at[k] == OFS_CFG) ? {4'h0, MODE_12, 2'h0} : 8'h00);
            wait_done(60, f);
            check("abort", {f, power_on}, 0);
        end
        foreach (ct[k]) begin
            wrt(OFS_CFG, {4'h0, MODE_12, ct[k]});
            wrt(OFS_SC1, 8'h09);
            repeat (4) @(posedge clk);
            stop_req <= 1'b1;
            repeat (3) @(posedge clk);
            stop_req <= 1'b0;
            wait_done(400, f);
            check("stop", f, k == 1);
        end
        $display("done: aborts");
        print_verdict();
    end
endmodule : tb
